// file: core/ctq_tx_path.sv
// Transmit queue, transmit buffer and transmit history of the CAN controller
`timescale 1ns/1ps
// Overview of operation
// - Up to eight queued frames, filled by host commands, emptied by successful sends or the clear command.
// - Run-enable pin or bit sends every queued frame; otherwise frames wait.
// - Without run-enable, single-shot bit 6 sends exactly one queued frame.
// - Run-enable or single-shot moves the oldest frame into the transmit buffer.
// - Abort command stops the frame on the bus at once.
// - Abort command 0x52 also clears run-enable and single-shot bits.
// - Withdrawn run-enable lets the current frame finish, then sending stops.
// - Success frees the buffer for the next frame and logs a history entry.
// - Lost arbitration keeps the frame in the buffer and retries it.
// - Frame error sets bus-error flag, interrupts if enabled, retries.
// - One-shot mode never retries; the failed frame stays queued.
// - Clear command 0x54 empties the queue; host reloads after one-shot failure.
// - Clear lets the current frame finish and clears run-enable and single-shot.
// - The identifier-extension bit selects standard or extended byte layout.
// - Payload beyond the length code is ignored; codes above 8 mean 8.
// - History keeps message tag and time tag of up to eight successes.
// - Time tag is the free-running counter when acknowledge is seen.
// - Command 0xEE reads tag, time high, time low per entry, then clears.
// - Queue-empty flag shows when the transmit queue holds nothing.
module ctq_tx_path
  import ctq_pkg::*;
#(
  parameter int unsigned QUEUE_DEPTH = QDEPTH,
  parameter int unsigned HIST_DEPTH  = QDEPTH
) (
  // System clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Host command stream from the serial engine
  input  wire logic        spi_cmd_valid,
  input  wire logic [7:0]  spi_cmd,
  input  wire logic        spi_byte_valid,
  input  wire logic [7:0]  spi_byte,
  input  wire logic        spi_cs_end,
  input  wire logic        hist_byte_req,
  output logic [7:0]       hist_byte,
  output logic             hist_byte_valid,
  // Host controls
  input  wire logic        control_reg_one_wr,
  input  wire logic [7:0]  control_reg_one_wdata,
  input  wire logic        tx_en_pin,
  input  wire logic        one_shot_mode,
  input  wire logic        bus_error_irq_enable,
  input  wire logic        bus_error_clr,
  // Status
  output logic             tx_run_enable,
  output logic             single_shot_send,
  output logic             tx_queue_empty_flag,
  output logic             bus_error_flag,
  output logic             irq_out,
  // Link to the bus protocol engine
  input  wire logic        link_clk,
  input  wire logic        can_tx_ok,
  input  wire logic        can_arb_lost,
  input  wire logic        can_tx_err,
  input  wire logic        can_ack_seen,
  output logic             can_tx_req,
  output logic             can_tx_abort,
  output logic [28:0]      can_id,
  output logic             can_ide,
  output logic             can_srr,
  output logic             can_rtr,
  output logic [3:0]       can_dlc,
  output logic [63:0]      can_data
);
  localparam int unsigned QAW = $clog2(QUEUE_DEPTH);
  localparam int unsigned HAW = $clog2(HIST_DEPTH);

  // System domain state
  logic [1:0]         pin_sync_ff;
  logic [2:0]         res_sync_ff;
  logic [2:0]         ack_sync_ff;
  logic               tx_run_enable_ff;
  logic               single_shot_ff;
  logic               bus_error_flag_ff;
  logic               irq_ff;
  logic               ld_active_ff;
  logic [3:0]         ld_cnt_ff;
  logic [FRAME_W-1:0] ld_buf_ff;
  logic [QAW-1:0]     q_wr_ptr_ff;
  logic [QAW-1:0]     q_rd_ptr_ff;
  logic [QAW:0]       q_cnt_ff;
  logic               q_empty_ff;
  ctq_state_e         state_ff;
  logic [FRAME_W-1:0] xbuf_ff;
  logic               req_tog_ff;
  logic               abort_tog_ff;
  logic               flushed_ff;
  logic               osm_block_ff;
  logic [TTAG_W-1:0]  ttag_cnt_ff;
  logic [TTAG_W-1:0]  ttag_ff;
  logic [HAW-1:0]     h_wr_ptr_ff;
  logic [HAW-1:0]     h_rd_ptr_ff;
  logic [HAW:0]       h_cnt_ff;
  logic               hr_active_ff;
  logic [1:0]         hr_phase_ff;
  logic [HAW:0]       hr_idx_ff;
  logic [7:0]         hist_byte_ff;
  logic               hist_byte_valid_ff;

  // Link domain state
  logic [1:0]         lrst_sync_ff;
  logic [2:0]         req_sync_ff;
  logic [2:0]         abort_sync_ff;
  logic               can_tx_req_ff;
  logic               can_tx_abort_ff;
  ctq_res_e           res_code_ff;
  logic               res_tog_ff;
  logic               ack_tog_ff;
  logic [28:0]        can_id_ff;
  logic               can_ide_ff;
  logic               can_srr_ff;
  logic               can_rtr_ff;
  logic [3:0]         can_dlc_ff;
  logic [63:0]        can_data_ff;

  // Combinational terms
  logic               cmd_load;
  logic               cmd_abort;
  logic               cmd_clear;
  logic               cmd_hist;
  logic               run_any;
  logic               send_allow;
  logic               res_evt;
  logic               send_done;
  logic               ok_done;
  logic               fail_done;
  logic               push;
  logic               pop;
  logic               h_write;
  logic               h_clear;
  logic               lrst;
  logic               req_edge;
  logic               abort_edge;
  logic               x_ide;
  logic [3:0]         x_dlc;
  logic [28:0]        x_id;
  logic [63:0]        x_data;

  ctq_ram_if #(.W(FRAME_W), .AW(QAW)) q_if ();
  ctq_ram_if #(.W(HIST_W), .AW(HAW))  h_if ();

  ctq_mem #(.W(FRAME_W), .DEPTH(QUEUE_DEPTH), .AW(QAW)) u_queue_mem (
    .clock (clock),
    .port  (q_if.mem)
  );

  ctq_mem #(.W(HIST_W), .DEPTH(HIST_DEPTH), .AW(HAW)) u_hist_mem (
    .clock (clock),
    .port  (h_if.mem)
  );

  assign cmd_load   = spi_cmd_valid && (spi_cmd == CMD_LOAD);
  assign cmd_abort  = spi_cmd_valid && (spi_cmd == CMD_ABORT);
  assign cmd_clear  = spi_cmd_valid && (spi_cmd == CMD_CLEAR);
  assign cmd_hist   = spi_cmd_valid && (spi_cmd == CMD_HIST);
  assign run_any    = tx_run_enable_ff | pin_sync_ff[1];
  assign send_allow = run_any | single_shot_ff;
  assign res_evt    = res_sync_ff[2] ^ res_sync_ff[1];
  assign send_done  = (state_ff == ST_SEND) && res_evt;
  assign ok_done    = send_done && (res_code_ff == RES_OK);
  assign fail_done  = send_done && ((res_code_ff == RES_ARB) || (res_code_ff == RES_ERR));
  // Full queue discards the load
  assign push = ld_active_ff && spi_cs_end && (ld_cnt_ff >= MIN_LOAD)
                && (q_cnt_ff != (QAW+1)'(QUEUE_DEPTH));
  assign pop  = ok_done && !flushed_ff && !cmd_clear;
  // Full history keeps old entries
  assign h_write = ok_done && (h_cnt_ff != (HAW+1)'(HIST_DEPTH));
  assign h_clear = hr_active_ff && spi_cs_end;

  assign q_if.wr_en   = push;
  assign q_if.wr_addr = q_wr_ptr_ff;
  assign q_if.wr_data = ld_buf_ff;
  assign q_if.rd_addr = q_rd_ptr_ff;
  assign h_if.wr_en   = h_write;
  assign h_if.wr_addr = h_clear ? '0 : h_wr_ptr_ff;
  assign h_if.wr_data = {xbuf_ff[8*TAG_BYTE +: 8], ttag_ff};
  assign h_if.rd_addr = h_rd_ptr_ff;

  // Pin synchroniser and result/acknowledge toggle receivers
  always_ff @(posedge clock) begin
    if (rst) begin
      pin_sync_ff <= 2'h0;
      res_sync_ff <= 3'h0;
      ack_sync_ff <= 3'h0;
    end else begin
      pin_sync_ff <= {pin_sync_ff[0], tx_en_pin};
      res_sync_ff <= {res_sync_ff[1:0], res_tog_ff};
      ack_sync_ff <= {ack_sync_ff[1:0], ack_tog_ff};
    end
  end

  // Host control bits; abort and clear take precedence over a write
  always_ff @(posedge clock) begin
    if (rst) begin
      tx_run_enable_ff <= RUN_RESET;
      single_shot_ff   <= SS_RESET;
    end else if (cmd_abort || cmd_clear) begin
      tx_run_enable_ff <= 1'h0;
      single_shot_ff   <= 1'h0;
    end else if (control_reg_one_wr) begin
      tx_run_enable_ff <= control_reg_one_wdata[RUN_BIT];
      single_shot_ff   <= control_reg_one_wdata[SS_BIT];
    end else if (ok_done) begin
      single_shot_ff   <= 1'h0;
    end
  end

  // Bus-error flag, set wins over clear, and the interrupt line
  always_ff @(posedge clock) begin
    if (rst) begin
      bus_error_flag_ff <= 1'h0;
      irq_ff            <= 1'h0;
    end else begin
      if (send_done && (res_code_ff == RES_ERR)) begin
        bus_error_flag_ff <= 1'h1;
      end else if (bus_error_clr) begin
        bus_error_flag_ff <= 1'h0;
      end
      irq_ff <= bus_error_flag_ff && bus_error_irq_enable;
    end
  end

  // Frame assembly from the load command
  always_ff @(posedge clock) begin
    if (rst) begin
      ld_active_ff <= 1'h0;
      ld_cnt_ff    <= 4'h0;
      ld_buf_ff    <= '0;
    end else if (cmd_load) begin
      ld_active_ff <= 1'h1;
      ld_cnt_ff    <= 4'h0;
      ld_buf_ff    <= '0;
    end else if (spi_cmd_valid || spi_cs_end) begin
      ld_active_ff <= 1'h0;
    end else if (ld_active_ff && spi_byte_valid && (ld_cnt_ff < 4'(FRAME_BYTES))) begin
      ld_buf_ff[8*ld_cnt_ff +: 8] <= spi_byte;
      ld_cnt_ff                   <= ld_cnt_ff + 4'h1;
    end
  end

  // Queue pointers, level and empty flag
  always_ff @(posedge clock) begin
    if (rst || cmd_clear) begin
      q_wr_ptr_ff <= '0;
      q_rd_ptr_ff <= '0;
      q_cnt_ff    <= '0;
      q_empty_ff  <= 1'h1;
    end else begin
      if (push) begin
        q_wr_ptr_ff <= q_wr_ptr_ff + QAW'(1);
      end
      if (pop) begin
        q_rd_ptr_ff <= q_rd_ptr_ff + QAW'(1);
      end
      q_cnt_ff   <= q_cnt_ff + (QAW+1)'(push) - (QAW+1)'(pop);
      q_empty_ff <= (q_cnt_ff + (QAW+1)'(push) - (QAW+1)'(pop)) == '0;
    end
  end

  // Transmit buffer sequencer
  always_ff @(posedge clock) begin
    if (rst) begin
      state_ff     <= ST_IDLE;
      xbuf_ff      <= '0;
      req_tog_ff   <= 1'h0;
      abort_tog_ff <= 1'h0;
      flushed_ff   <= 1'h0;
      osm_block_ff <= 1'h0;
    end else begin
      if (cmd_clear) begin
        osm_block_ff <= 1'h0;
      end
      case (state_ff)
        ST_IDLE: begin
          if (send_allow && (q_cnt_ff != '0) && !osm_block_ff && !cmd_clear) begin
            state_ff <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          if (cmd_abort || cmd_clear || !send_allow) begin
            state_ff <= ST_IDLE;
          end else begin
            xbuf_ff    <= q_if.rd_data;
            req_tog_ff <= ~req_tog_ff;
            flushed_ff <= 1'h0;
            state_ff   <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (cmd_clear) begin
            flushed_ff <= 1'h1;
          end
          if (cmd_abort) begin
            abort_tog_ff <= ~abort_tog_ff;
          end
          if (fail_done && one_shot_mode) begin
            osm_block_ff <= 1'h1;
            state_ff     <= ST_IDLE;
          end else if (fail_done && send_allow && !flushed_ff && !cmd_clear
                       && !cmd_abort) begin
            req_tog_ff <= ~req_tog_ff;
          end else if (send_done) begin
            state_ff <= ST_IDLE;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // Free-running counter, sampled when the acknowledge arrives
  always_ff @(posedge clock) begin
    if (rst) begin
      ttag_cnt_ff <= '0;
      ttag_ff     <= '0;
    end else begin
      ttag_cnt_ff <= ttag_cnt_ff + TTAG_W'(1);
      if (ack_sync_ff[2] ^ ack_sync_ff[1]) begin
        ttag_ff <= ttag_cnt_ff;
      end
    end
  end

  // History write side; a new entry survives a clear in the same cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      h_wr_ptr_ff <= '0;
      h_cnt_ff    <= '0;
    end else if (h_clear) begin
      h_wr_ptr_ff <= HAW'(h_write);
      h_cnt_ff    <= (HAW+1)'(h_write);
    end else if (h_write) begin
      h_wr_ptr_ff <= h_wr_ptr_ff + HAW'(1);
      h_cnt_ff    <= h_cnt_ff + (HAW+1)'(1);
    end
  end

  // History read side: three bytes per entry, zero past the last entry
  always_ff @(posedge clock) begin
    if (rst) begin
      hr_active_ff       <= 1'h0;
      hr_phase_ff        <= 2'h0;
      hr_idx_ff          <= '0;
      h_rd_ptr_ff        <= '0;
      hist_byte_ff       <= 8'h0;
      hist_byte_valid_ff <= 1'h0;
    end else begin
      hist_byte_valid_ff <= 1'h0;
      if (cmd_hist) begin
        hr_active_ff <= 1'h1;
        hr_phase_ff  <= 2'h0;
        hr_idx_ff    <= '0;
        h_rd_ptr_ff  <= '0;
      end else if (spi_cmd_valid || spi_cs_end) begin
        hr_active_ff <= 1'h0;
        h_rd_ptr_ff  <= '0;
      end else if (hr_active_ff && hist_byte_req) begin
        hist_byte_valid_ff <= 1'h1;
        if (hr_idx_ff >= h_cnt_ff) begin
          hist_byte_ff <= 8'h0;
        end else begin
          case (hr_phase_ff)
            2'h0:    hist_byte_ff <= h_if.rd_data[HIST_W-1 -: 8];
            2'h1:    hist_byte_ff <= h_if.rd_data[TTAG_W-1 -: 8];
            default: hist_byte_ff <= h_if.rd_data[7:0];
          endcase
        end
        if (hr_phase_ff == 2'h2) begin
          hr_phase_ff <= 2'h0;
          hr_idx_ff   <= hr_idx_ff + (HAW+1)'(1);
          h_rd_ptr_ff <= h_rd_ptr_ff + HAW'(1);
        end else begin
          hr_phase_ff <= hr_phase_ff + 2'h1;
        end
      end
    end
  end

  // Link domain: reset and event synchronisers
  assign lrst       = lrst_sync_ff[1];
  assign req_edge   = req_sync_ff[2] ^ req_sync_ff[1];
  assign abort_edge = abort_sync_ff[2] ^ abort_sync_ff[1];

  always_ff @(posedge link_clk) begin
    lrst_sync_ff <= {lrst_sync_ff[0], rst};
  end

  always_ff @(posedge link_clk) begin
    if (lrst) begin
      req_sync_ff   <= 3'h0;
      abort_sync_ff <= 3'h0;
    end else begin
      req_sync_ff   <= {req_sync_ff[1:0], req_tog_ff};
      abort_sync_ff <= {abort_sync_ff[1:0], abort_tog_ff};
    end
  end

  // Decode of the buffered frame; the buffer is stable while a request is open
  always_comb begin
    x_ide  = xbuf_ff[8*IDE_BYTE + IDE_BIT];
    x_dlc  = x_ide ? xbuf_ff[8*EXT_DLC_BYTE +: 4] : xbuf_ff[8*STD_DLC_BYTE +: 4];
    if (x_dlc > MAX_DLC) begin
      x_dlc = MAX_DLC;
    end
    x_id = x_ide ? {xbuf_ff[8*1 +: 8], xbuf_ff[8*2+5 +: 3], xbuf_ff[8*2 +: 3],
                    xbuf_ff[8*3 +: 8], xbuf_ff[8*4+1 +: 7]}
                 : {18'h0, xbuf_ff[8*1 +: 8], xbuf_ff[8*2+5 +: 3]};
    for (int i = 0; i < 8; i++) begin
      if (4'(i) < x_dlc) begin
        x_data[8*i +: 8] = x_ide ? xbuf_ff[8*(EXT_DATA_BYTE+i) +: 8]
                                 : xbuf_ff[8*(STD_DATA_BYTE+i) +: 8];
      end else begin
        x_data[8*i +: 8] = 8'h0;
      end
    end
  end

  // Link-side request, abort and result reporting
  always_ff @(posedge link_clk) begin
    if (lrst) begin
      can_tx_req_ff   <= 1'h0;
      can_tx_abort_ff <= 1'h0;
      res_code_ff     <= RES_OK;
      res_tog_ff      <= 1'h0;
      can_id_ff       <= '0;
      can_ide_ff      <= 1'h0;
      can_srr_ff      <= 1'h0;
      can_rtr_ff      <= 1'h0;
      can_dlc_ff      <= 4'h0;
      can_data_ff     <= '0;
    end else begin
      can_tx_abort_ff <= 1'h0;
      if (req_edge) begin
        can_tx_req_ff <= 1'h1;
        can_id_ff     <= x_id;
        can_ide_ff    <= x_ide;
        can_srr_ff    <= x_ide & xbuf_ff[8*IDE_BYTE + FLAG_BIT];
        can_rtr_ff    <= x_ide ? xbuf_ff[8*4] : xbuf_ff[8*IDE_BYTE + FLAG_BIT];
        can_dlc_ff    <= x_dlc;
        can_data_ff   <= x_data;
      end else if (can_tx_req_ff && abort_edge) begin
        can_tx_req_ff   <= 1'h0;
        can_tx_abort_ff <= 1'h1;
        res_code_ff     <= RES_ABORT;
        res_tog_ff      <= ~res_tog_ff;
      end else if (can_tx_req_ff && (can_tx_ok || can_arb_lost || can_tx_err)) begin
        can_tx_req_ff <= 1'h0;
        res_code_ff   <= can_tx_ok ? RES_OK : (can_arb_lost ? RES_ARB : RES_ERR);
        res_tog_ff    <= ~res_tog_ff;
      end
    end
  end

  always_ff @(posedge link_clk) begin
    if (lrst) begin
      ack_tog_ff <= 1'h0;
    end else if (can_tx_req_ff && can_ack_seen) begin
      ack_tog_ff <= ~ack_tog_ff;
    end
  end

  // Outputs
  assign hist_byte           = hist_byte_ff;
  assign hist_byte_valid     = hist_byte_valid_ff;
  assign tx_run_enable       = tx_run_enable_ff;
  assign single_shot_send    = single_shot_ff;
  assign tx_queue_empty_flag = q_empty_ff;
  assign bus_error_flag      = bus_error_flag_ff;
  assign irq_out             = irq_ff;
  assign can_tx_req          = can_tx_req_ff;
  assign can_tx_abort        = can_tx_abort_ff;
  assign can_id              = can_id_ff;
  assign can_ide             = can_ide_ff;
  assign can_srr             = can_srr_ff;
  assign can_rtr             = can_rtr_ff;
  assign can_dlc             = can_dlc_ff;
  assign can_data            = can_data_ff;
endmodule

// file: core/ctq_pkg.sv
// Shared constants and types of the CAN transmit queue path
package ctq_pkg;

  // Sizes
  localparam int unsigned QDEPTH      = 8;
  localparam int unsigned FRAME_BYTES = 14;
  localparam int unsigned FRAME_W     = 8 * FRAME_BYTES;
  localparam int unsigned TTAG_W      = 16;
  localparam int unsigned HIST_W      = 8 + TTAG_W;

  // Host command codes
  localparam logic [7:0] CMD_LOAD  = 8'h12;
  localparam logic [7:0] CMD_ABORT = 8'h52;
  localparam logic [7:0] CMD_CLEAR = 8'h54;
  localparam logic [7:0] CMD_HIST  = 8'hee;

  // Control register one bit positions
  localparam int unsigned RUN_BIT = 7;
  localparam int unsigned SS_BIT  = 6;

  // Loaded frame layout (byte indices from 0 = message tag)
  localparam int unsigned TAG_BYTE      = 0;
  localparam int unsigned IDE_BYTE      = 2;
  localparam int unsigned IDE_BIT       = 3;
  localparam int unsigned FLAG_BIT      = 4;
  localparam int unsigned STD_DLC_BYTE  = 3;
  localparam int unsigned STD_DATA_BYTE = 4;
  localparam int unsigned EXT_DLC_BYTE  = 5;
  localparam int unsigned EXT_DATA_BYTE = 6;
  localparam logic [3:0]  MIN_LOAD      = 4'h4;
  localparam logic [3:0]  MAX_DLC       = 4'h8;

  // Reset values of host controls
  localparam logic RUN_RESET = 1'h0;
  localparam logic SS_RESET  = 1'h0;

  // Outcome of one attempt on the bus
  typedef enum logic [1:0] {
    RES_OK    = 2'h0,
    RES_ARB   = 2'h1,
    RES_ERR   = 2'h2,
    RES_ABORT = 2'h3
  } ctq_res_e;

  // Transmit buffer sequencer
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_FETCH = 3'h2,
    ST_SEND  = 3'h4
  } ctq_state_e;

endpackage

// file: core/ctq_ram_if.sv
// Port bundle between the path and its small memories
`timescale 1ns/1ps
interface ctq_ram_if #(
  parameter int unsigned W  = 8,
  parameter int unsigned AW = 3
) ();
  logic          wr_en;
  logic [AW-1:0] wr_addr;
  logic [W-1:0]  wr_data;
  logic [AW-1:0] rd_addr;
  logic [W-1:0]  rd_data;

  modport ctl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// file: core/ctq_mem.sv
// Small synchronous memory with registered read data
`timescale 1ns/1ps
module ctq_mem #(
  parameter int unsigned W     = 8,
  parameter int unsigned DEPTH = 8,
  parameter int unsigned AW    = 3
) (
  // Clock
  input wire logic clock,
  // Access port
  ctq_ram_if.mem   port
);
  logic [W-1:0] mem_ff [DEPTH];

  always_ff @(posedge clock) begin
    if (port.wr_en) begin
      mem_ff[port.wr_addr] <= port.wr_data;
    end
  end

  always_ff @(posedge clock) begin
    port.rd_data <= mem_ff[port.rd_addr];
  end
endmodule

// file: testbench/ctq_tx_monitor.sv
// Assertion checker of the CAN transmit queue path
`timescale 1ns/1ps
module ctq_tx_monitor import ctq_pkg::*; (
  // System side
  input wire logic        clock, rst, spi_cmd_valid, control_reg_one_wr, tx_run_enable,
  input wire logic        single_shot_send, tx_queue_empty_flag, bus_error_flag,
  input wire logic        bus_error_irq_enable, irq_out,
  input wire logic [7:0]  spi_cmd, control_reg_one_wdata,
  // Link side
  input wire logic        link_clk, can_tx_ok, can_tx_req, can_tx_abort,
  input wire logic [3:0]  can_dlc,
  input wire logic [63:0] can_data
);
  sequence s_abort; spi_cmd_valid && spi_cmd == CMD_ABORT; endsequence
  sequence s_clear; spi_cmd_valid && spi_cmd == CMD_CLEAR; endsequence
  property p_irq; @(posedge clock) disable iff (rst)
    irq_out == $past(bus_error_flag && bus_error_irq_enable); endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");
  property p_abort_bits; @(posedge clock) disable iff (rst)
    s_abort |=> !tx_run_enable && !single_shot_send; endproperty
  a_abort_bits: assert property (p_abort_bits) else $error("abort kept bits");
  property p_clear_bits; @(posedge clock) disable iff (rst)
    s_clear |=> !tx_run_enable && !single_shot_send; endproperty
  a_clear_bits: assert property (p_clear_bits) else $error("clear kept bits");
  property p_clear_empty; @(posedge clock) disable iff (rst)
    s_clear |-> ##[1:2] tx_queue_empty_flag; endproperty
  a_clear_empty: assert property (p_clear_empty) else $error("queue not empty");
  property p_run_wr; @(posedge clock) disable iff (rst)
    control_reg_one_wr && !spi_cmd_valid |=> tx_run_enable == $past(control_reg_one_wdata[RUN_BIT]); endproperty
  a_run_wr: assert property (p_run_wr) else $error("run bit wrong");
  property p_ok_drop; @(posedge link_clk) disable iff (rst)
    can_tx_ok && can_tx_req |=> !can_tx_req; endproperty
  a_ok_drop: assert property (p_ok_drop) else $error("request held");
  property p_pad; @(posedge link_clk) disable iff (rst)
    can_tx_req |-> can_dlc <= MAX_DLC && (can_data >> {can_dlc, 3'h0}) == 64'h0; endproperty
  a_pad: assert property (p_pad) else $error("payload not clamped");
  property p_abort_drop; @(posedge link_clk) disable iff (rst)
    can_tx_abort |=> !can_tx_abort && !can_tx_req; endproperty
  a_abort_drop: assert property (p_abort_drop) else $error("abort not final");
endmodule

bind ctq_tx_path ctq_tx_monitor u_mon (.*);

// file: testbench/ctq_can_engine.sv
// Bus engine model answering transmit requests on the link clock
`timescale 1ns/1ps
module ctq_can_engine (
  input wire logic       link_clk, can_tx_req, can_tx_abort,
  input wire logic [1:0] eng_mode,
  output logic           can_tx_ok, can_arb_lost, can_tx_err, can_ack_seen
);
  logic [3:0] cnt_ff = 4'h0;
  wire        fin = can_tx_req && cnt_ff == 4'h9;
  initial {can_tx_ok, can_arb_lost, can_tx_err, can_ack_seen} = 4'h0;
  // Mode 0 success, 1 lost arbitration, 2 frame error, 3 stall forever
  always @(posedge link_clk) begin
    cnt_ff <= (can_tx_req && !can_tx_abort && cnt_ff != 4'hf) ? cnt_ff + 4'h1 : 4'h0;
    can_ack_seen <= can_tx_req && cnt_ff == 4'h8 && eng_mode == 2'h0;
    can_tx_ok <= fin && eng_mode == 2'h0;
    can_arb_lost <= fin && eng_mode == 2'h1;
    can_tx_err <= fin && eng_mode == 2'h2;
  end
endmodule

// file: testbench/tb_ctq_tx_path.sv
// Self-checking bench of the CAN transmit queue path
`timescale 1ns/1ps
module tb_ctq_tx_path import ctq_pkg::*; ;
  logic clock, rst, link_clk, spi_cmd_valid, spi_byte_valid, spi_cs_end, hist_byte_req;
  logic control_reg_one_wr, tx_en_pin, one_shot_mode, bus_error_irq_enable, bus_error_clr, can_ack_seen;
  logic hist_byte_valid, tx_run_enable, single_shot_send, tx_queue_empty_flag, bus_error_flag;
  logic irq_out, can_tx_ok, can_arb_lost, can_tx_err, can_tx_req, can_tx_abort;
  logic can_ide, can_srr, can_rtr;
  logic [7:0] spi_cmd, spi_byte, control_reg_one_wdata, hist_byte;
  logic [3:0] can_dlc, d;
  logic [28:0] can_id;
  logic [63:0] can_data, dat;
  logic [1:0] eng_mode;
  logic [31:0] seed = 32'hd280;
  int n_mismatch, tests_run, n_req, n0;
  bit x;
  ctq_tx_path DUT (.*);
  ctq_can_engine u_eng (.*);
  initial begin clock = 0; forever #4 clock = ~clock; end
  initial begin link_clk = 0; #1.7; forever #6 link_clk = ~link_clk; end
  always @(posedge can_tx_req) n_req++;
  initial begin #400000; n_mismatch++; end_of_test(); end
  function logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  // Identifiers that load() writes for the standard and the extended layout
  function logic [28:0] exp_id(input bit ext);
    return ext ? 29'hb541e40 : 29'h2d5;
  endfunction
  task automatic chk(input logic [63:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n = 1); repeat (n) @(posedge clock); #1; endtask
  task automatic cmd(input logic [7:0] c);
    spi_cmd_valid = 1; spi_cmd = c; tick(); spi_cmd_valid = 0; tick();
  endtask
  task automatic ctrl(input logic [7:0] v);
    control_reg_one_wr = 1; control_reg_one_wdata = v; tick(); control_reg_one_wr = 0; tick();
  endtask
  task automatic wait_on(input bit emp);
    for (int i = 0; i < 1500 && (emp ? tx_queue_empty_flag !== 1 : can_tx_req !== 1); i++) tick();
    chk(emp ? tx_queue_empty_flag : can_tx_req, 1);
  endtask
  // Standard or extended frame, always all payload bytes so bytes past the length code are ignored
  task automatic load(input logic [7:0] tag, input bit ext = 0);
    d = 4'(rnd());
    dat = {rnd(), rnd()};
    cmd(CMD_LOAD);
    for (int i = 0; i < (ext ? 14 : 12); i++) begin
      spi_byte_valid = 1;
      if (ext && i > 1 && i < 5) spi_byte = i == 2 ? 8'ha8 : i == 3 ? 8'h3c : 8'h80;
      else if (i == (ext ? 5 : 3)) spi_byte = {4'h0, d};
      else spi_byte = i == 0 ? tag : i == 1 ? 8'h5a : i == 2 ? 8'ha0
                      : dat[8*(i-(ext ? 6 : 4)) +: 8];
      tick();
    end
    spi_byte_valid = 0; spi_cs_end = 1; tick(); spi_cs_end = 0; tick();
  endtask
  task automatic end_of_test();
    if (n_mismatch == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    {rst, spi_cmd_valid, spi_byte_valid, spi_cs_end, hist_byte_req, control_reg_one_wr, tx_en_pin} = 7'h40;
    {one_shot_mode, bus_error_irq_enable, bus_error_clr, spi_cmd, spi_byte, control_reg_one_wdata} = 27'h2000000;
    eng_mode = 0;
    tick(4); rst = 0; tick(4);
    chk(tx_queue_empty_flag, 1);
    for (int k = 0; k < 4; k++) begin
      x = k == 3;
      load(8'(8'h30 + k), x); tick(40);
      chk(n_req, k);
      ctrl(8'h80); wait_on(0);
      chk({can_id, can_ide, can_dlc}, {exp_id(x), x, d > 8 ? 4'h8 : d});
      chk(can_data, d >= 8 ? dat : dat & ~({64{1'b1}} << {d, 3'h0}));
      wait_on(1); chk(tx_queue_empty_flag, 1);
      cmd(CMD_HIST); hist_byte_req = 1; tick(); hist_byte_req = 0;
      chk(hist_byte_valid, 1); tick(2);
      chk(hist_byte, 8'h30 + k);
      spi_cs_end = 1; tick(); spi_cs_end = 0; tick(); ctrl(8'h00);
    end
    ctrl(8'h00); n0 = n_req;
    for (int k = 0; k < 9; k++) load(8'(k));
    tx_en_pin = 1; wait_on(1); tick(50); tx_en_pin = 0;
    chk(n_req - n0, 8);
    load(1); load(2); n0 = n_req; ctrl(8'h40); tick(300);
    chk({n_req - n0, tx_queue_empty_flag}, 2);
    eng_mode = 1; n0 = n_req; ctrl(8'h80); tick(200);
    chk(n_req - n0 > 1, 1);
    eng_mode = 2; tick(200);
    chk({bus_error_flag, irq_out}, 3);
    eng_mode = 3; tick(100); cmd(CMD_ABORT); tick(20);
    chk({can_tx_req, tx_run_enable, tx_queue_empty_flag}, 0);
    one_shot_mode = 1; eng_mode = 1; n0 = n_req; ctrl(8'h80); tick(300);
    chk({n_req - n0, tx_queue_empty_flag}, 2);
    cmd(CMD_CLEAR); tick(3);
    chk(tx_queue_empty_flag, 1);
    bus_error_clr = 1; tick(); bus_error_clr = 0; tick();
    chk({bus_error_flag, irq_out}, 0);
    end_of_test();
  end
endmodule
